// ===== core/hps_pkg.sv
// Purpose: shared constants and types of the host port pin selector
// Assumes: one 40 MHz system clock, pins sampled by two flip-flops
// Notes: sync bit positions are used by the top only; the pin bank handles the whole vector
package hps_pkg;
    // ==========================================================
    // widths
    localparam int NUM_GPIO = 4;
    localparam int STRAP_W = 2;
    localparam int LINE_CTRL_W = 8;
    localparam int RTS_CTRL_BIT = 7;
    localparam int SYNC_W = 12;
    // ==========================================================
    // positions inside the synchroniser bank
    localparam int SI_RESET_N = 0;
    localparam int SI_SEL = 1;
    localparam int SI_SCLK = 2;
    localparam int SI_CS = 3;
    localparam int SI_DIN = 4;
    localparam int SI_SDA = 5;
    localparam int SI_CTS = 6;
    localparam int SI_RX = 7;
    localparam int SI_GEN_PIN0 = 8;
    // ==========================================================
    // values after reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 12'h000;
    localparam logic RTS_N_RST = 1'b0;
    localparam logic CS_N_IDLE = 1'b1;
    localparam logic TX_IDLE = 1'b1;
    localparam logic MODE_SPI_RST = 1'b1;
    // ==========================================================
    // timing
    localparam int CLK_KHZ = 40000;
    localparam int I2C_SCL_MAX_KHZ = 400;
    localparam int I2C_SCL_MIN_CYC = (CLK_KHZ + I2C_SCL_MAX_KHZ - 1) / I2C_SCL_MAX_KHZ;
    localparam int RATE_CNT_W = 7;
    localparam logic [RATE_CNT_W-1:0] RATE_CNT_MAX = 7'h7F;
    localparam logic [RATE_CNT_W-1:0] RATE_MIN = RATE_CNT_W'(I2C_SCL_MIN_CYC);
    typedef enum logic {HPS_HW_RESET, HPS_RUN} hps_state_t;
endpackage

// ===== core/hps_sync_if.sv
// Purpose: carrier between the top and its pin synchroniser bank
// Assumes: raw pin levels in, two-stage synchronised levels out
// Notes: none
`timescale 1ns/10ps
interface hps_sync_if;
    import hps_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] synced;
    modport feed (output raw, input synced);
    modport bank (input raw, output synced);
endinterface

// ===== core/hps_sync_bank.sv
// Purpose: two flip-flop synchroniser for every input pin
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
module hps_sync_bank
    import hps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    hps_sync_if.bank sif
);
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] stable_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= SYNC_RST;
            stable_reg <= SYNC_RST;
        end else begin
            meta_reg <= sif.raw;
            stable_reg <= meta_reg;
        end
    end

    assign sif.synced = stable_reg;
endmodule

// ===== core/hps_pin_select.sv
// Purpose: host port pin selection and pin functions of a serial UART
// Assumes: mode select and address straps static while running
// Notes: all outputs registered; pins pass a two-stage synchroniser
`timescale 1ns/10ps
module hps_pin_select
    import hps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reset_n_pin,
    input wire logic spi_select_pin,
    input wire logic sclk_scl_pin,
    input wire logic select_or_addr_strap0,
    input wire logic serial_in_or_addr_strap1,
    input wire logic dout_sda_i,
    output logic dout_sda_o,
    output logic dout_sda_oe,
    output logic irq_n_o,
    output logic irq_n_oe,
    input wire logic clear_to_send_n,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic request_to_send_n,
    input wire logic [NUM_GPIO-1:0] general_pin_i,
    output logic [NUM_GPIO-1:0] general_pin_o,
    output logic [NUM_GPIO-1:0] general_pin_oe,
    input wire logic spi_miso,
    input wire logic i2c_sda_drive_low,
    input wire logic irq_pending,
    input wire logic [LINE_CTRL_W-1:0] line_control_register,
    input wire logic tx_data,
    input wire logic [NUM_GPIO-1:0] gpio_dir_out,
    input wire logic [NUM_GPIO-1:0] gpio_open_drain,
    input wire logic [NUM_GPIO-1:0] gpio_out_data,
    output logic mode_spi,
    output logic [STRAP_W-1:0] addr_strap,
    output logic spi_cs_n,
    output logic spi_mosi,
    output logic spi_sclk_rise,
    output logic spi_sclk_fall,
    output logic i2c_scl,
    output logic i2c_sda_in,
    output logic scl_rate_fault,
    output logic core_reset,
    output logic clock_enable,
    output logic cts_n_sync,
    output logic rx_sync,
    output logic [NUM_GPIO-1:0] gpio_in_data
);
    // ==========================================================
    // pin synchronisers
    hps_sync_if sif ();
    logic [SYNC_W-1:0] s;
    logic sclk_last_reg;
    logic [RATE_CNT_W-1:0] rate_cnt_reg;
    hps_state_t state_reg;
    logic run;

    assign sif.raw = {general_pin_i, rx_pin, clear_to_send_n, dout_sda_i,
                      serial_in_or_addr_strap1, select_or_addr_strap0, sclk_scl_pin,
                      spi_select_pin, reset_n_pin};
    assign s = sif.synced;
    assign run = (state_reg == HPS_RUN);

    hps_sync_bank u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .sif(sif)
    );

    // ==========================================================
    // hardware reset state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= HPS_HW_RESET;
            core_reset <= 1'b1;
            clock_enable <= 1'b0;
        end else begin
            unique case (state_reg)
                HPS_HW_RESET: begin
                    if (s[SI_RESET_N]) begin
                        state_reg <= HPS_RUN;
                    end
                end
                HPS_RUN: begin
                    if (!s[SI_RESET_N]) begin
                        state_reg <= HPS_HW_RESET;
                    end
                end
            endcase
            core_reset <= !s[SI_RESET_N];
            clock_enable <= s[SI_RESET_N];
        end
    end

    // ==========================================================
    // mode and straps caught while held in hardware reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_spi <= MODE_SPI_RST;
            addr_strap <= '0;
        end else if (!run) begin
            mode_spi <= s[SI_SEL];
            addr_strap <= {s[SI_DIN], s[SI_CS]};
        end
    end

    // ==========================================================
    // shared host pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            spi_cs_n <= CS_N_IDLE;
            spi_mosi <= 1'b0;
            i2c_scl <= 1'b1;
            i2c_sda_in <= 1'b1;
            dout_sda_o <= 1'b0;
            dout_sda_oe <= 1'b0;
        end else if (mode_spi) begin
            spi_cs_n <= s[SI_CS] || !run;
            spi_mosi <= s[SI_DIN];
            i2c_scl <= 1'b1;
            i2c_sda_in <= 1'b1;
            dout_sda_o <= spi_miso;
            dout_sda_oe <= run && !s[SI_CS];
        end else begin
            spi_cs_n <= CS_N_IDLE;
            spi_mosi <= 1'b0;
            i2c_scl <= s[SI_SCLK];
            i2c_sda_in <= s[SI_SDA];
            dout_sda_o <= 1'b0;
            dout_sda_oe <= run && i2c_sda_drive_low;
        end
    end

    // ==========================================================
    // clock edges and I2C rate check
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_last_reg <= 1'b0;
            spi_sclk_rise <= 1'b0;
            spi_sclk_fall <= 1'b0;
        end else begin
            sclk_last_reg <= s[SI_SCLK];
            spi_sclk_rise <= run && mode_spi && s[SI_SCLK] && !sclk_last_reg;
            spi_sclk_fall <= run && mode_spi && !s[SI_SCLK] && sclk_last_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_cnt_reg <= '0;
            scl_rate_fault <= 1'b0;
        end else if (!run || mode_spi) begin
            rate_cnt_reg <= '0;
            scl_rate_fault <= 1'b0;
        end else if (s[SI_SCLK] && !sclk_last_reg) begin
            // zero means no scl rise seen yet in this run, so the first rise is never a fault
            rate_cnt_reg <= RATE_CNT_W'(1'b1);
            if (rate_cnt_reg != '0 && rate_cnt_reg < RATE_MIN) begin
                scl_rate_fault <= 1'b1;
            end
        end else if (rate_cnt_reg != '0 && rate_cnt_reg != RATE_CNT_MAX) begin
            rate_cnt_reg <= rate_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // interrupt, UART pins and flow control
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_n_o <= 1'b0;
            irq_n_oe <= 1'b0;
            tx_pin <= TX_IDLE;
            rx_sync <= 1'b1;
            cts_n_sync <= 1'b1;
            request_to_send_n <= RTS_N_RST;
        end else begin
            irq_n_o <= 1'b0;
            irq_n_oe <= run && irq_pending;
            tx_pin <= run ? tx_data : TX_IDLE;
            rx_sync <= s[SI_RX];
            cts_n_sync <= s[SI_CTS];
            request_to_send_n <= line_control_register[RTS_CTRL_BIT];
        end
    end

    // ==========================================================
    // general pins
    genvar g;
    generate
        for (g = 0; g < NUM_GPIO; g++) begin : gen_gpio
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    general_pin_o[g] <= 1'b0;
                    general_pin_oe[g] <= 1'b0;
                    gpio_in_data[g] <= 1'b0;
                end else begin
                    general_pin_o[g] <= gpio_open_drain[g] ? 1'b0 : gpio_out_data[g];
                    general_pin_oe[g] <= gpio_dir_out[g] &&
                        (!gpio_open_drain[g] || !gpio_out_data[g]);
                    gpio_in_data[g] <= s[SI_GEN_PIN0+g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // assertions
    property p_mode_static;
        @(posedge sys_clk) disable iff (rst) run && $past(run) |-> $stable(mode_spi);
    endproperty
    a_mode_static: assert property (p_mode_static) else $error("mode changed in run");
    property p_sda_i2c;
        @(posedge sys_clk) disable iff (rst)
            !$past(rst) && !$past(mode_spi) |-> dout_sda_o == 1'b0 &&
            dout_sda_oe == ($past(run) && $past(i2c_sda_drive_low));
    endproperty
    a_sda_i2c: assert property (p_sda_i2c) else $error("sda drive wrong");
    property p_sda_spi;
        @(posedge sys_clk) disable iff (rst)
            !$past(rst) && $past(mode_spi) |-> dout_sda_o == $past(spi_miso);
    endproperty
    a_sda_spi: assert property (p_sda_spi) else $error("spi output not routed");
    property p_scl_route;
        @(posedge sys_clk) disable iff (rst)
            !$past(rst) && !$past(mode_spi) |-> i2c_scl == $past(s[SI_SCLK]);
    endproperty
    a_scl_route: assert property (p_scl_route) else $error("scl not routed");
    property p_cs_idle;
        @(posedge sys_clk) disable iff (rst)
            !mode_spi ##1 !mode_spi |-> spi_cs_n && !spi_sclk_rise;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("spi active in i2c");
    property p_strap_hold;
        @(posedge sys_clk) disable iff (rst) run ##1 run |-> $stable(addr_strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
    property p_irq;
        @(posedge sys_clk) disable iff (rst)
            run && irq_pending |=> irq_n_oe && !irq_n_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not asserted");
    property p_hw_reset;
        @(posedge sys_clk) disable iff (rst)
            !s[SI_RESET_N] |=> core_reset && !clock_enable ##1 !spi_sclk_rise;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("clock active in reset");
    property p_rts;
        @(posedge sys_clk) disable iff (rst)
            !$past(rst) |-> request_to_send_n == $past(line_control_register[RTS_CTRL_BIT]);
    endproperty
    a_rts: assert property (p_rts) else $error("rts mismatch");
    property p_gpio_od;
        @(posedge sys_clk) disable iff (rst)
            !$past(rst) && $past(gpio_open_drain[0]) |-> !general_pin_o[0] &&
            general_pin_oe[0] == ($past(gpio_dir_out[0]) && !$past(gpio_out_data[0]));
    endproperty
    a_gpio_od: assert property (p_gpio_od) else $error("open drain wrong");
    property p_cts;
        @(posedge sys_clk) disable iff (rst) !$past(rst) |-> cts_n_sync == $past(s[SI_CTS]);
    endproperty
    a_cts: assert property (p_cts) else $error("cts not passed");
    property p_tx;
        @(posedge sys_clk) disable iff (rst)
            $past(run) && !$past(rst) |-> tx_pin == $past(tx_data);
    endproperty
    a_tx: assert property (p_tx) else $error("tx not passed");
    c_spi_rise: cover property (@(posedge sys_clk) disable iff (rst) spi_sclk_rise);
    c_i2c_drive: cover property (@(posedge sys_clk) disable iff (rst)
        run && !mode_spi && dout_sda_oe);
    c_rate_fault: cover property (@(posedge sys_clk) disable iff (rst) scl_rate_fault);
    c_reenter: cover property (@(posedge sys_clk) disable iff (rst) run ##1 !run);
endmodule

// ===== dv/hps_host_model.sv
// Purpose: host controller model driving the shared host port pins
// Assumes: spi clock period 200 ns, i2c clock period 2.6 us unless told faster
// Notes: spi clock stands low outside frames, i2c clock idles high
`timescale 1ns/10ps
module hps_host_model (
    output logic sel,
    output logic sclk,
    output logic cs_strap0,
    output logic din_strap1,
    output logic sda_low,
    input wire logic sda_wire
);
    logic [7:0] rx;
    initial begin
        sel = 1'h1;
        sclk = 1'h0;
        cs_strap0 = 1'h1;
        din_strap1 = 1'h0;
        sda_low = 1'h0;
        rx = 8'h00;
    end
    // ==========================================================
    // straps, only called while the device is held in reset
    task automatic strap(input logic mode, input logic [1:0] a);
        sel = mode;
        sclk = !mode;
        cs_strap0 = mode ? 1'h1 : a[0];
        din_strap1 = mode ? 1'h0 : a[1];
    endtask
    // ==========================================================
    // one spi byte, msb first, data read back on each rising clock
    task automatic spi_byte(input logic [7:0] d);
        cs_strap0 = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            din_strap1 = d[i];
            #100;
            sclk = 1'h1;
            rx = {rx[6:0], sda_wire};
            #100;
            sclk = 1'h0;
        end
        cs_strap0 = 1'h1;
        din_strap1 = !d[0];
    endtask
    task automatic scl_pulses(input int n, input int half);
        repeat (n) begin
            sclk = 1'h0;
            #half;
            sclk = 1'h1;
            #half;
        end
    endtask
endmodule

// ===== dv/tb_host_port_pin_select.sv
// Purpose: self-checking bench of the host port pin selector
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes: data pin has a pull-up, released general pins see an outside level
`timescale 1ns/10ps
module tb_host_port_pin_select;
    import hps_pkg::*;
    logic sys_clk = 1'h0, rst = 1'h1, reset_n_pin = 1'h0;
    wire logic spi_select_pin, sclk_scl_pin, select_or_addr_strap0, serial_in_or_addr_strap1;
    wire logic sda_low, dout_sda_i;
    logic spi_miso = 1'h0, i2c_sda_drive_low = 1'h0, irq_pending = 1'h0, tx_data = 1'h1;
    logic clear_to_send_n = 1'h1, rx_pin = 1'h1;
    logic [LINE_CTRL_W-1:0] line_control_register = 8'h05;
    logic [NUM_GPIO-1:0] gpio_dir_out = 4'h0, gpio_open_drain = 4'h0, gpio_out_data = 4'h0;
    wire logic [NUM_GPIO-1:0] general_pin_i;
    logic [NUM_GPIO-1:0] gpio_ext = 4'h9, pin_exp;
    logic dout_sda_o, dout_sda_oe, irq_n_o, irq_n_oe, tx_pin, request_to_send_n, mode_spi;
    logic spi_cs_n, spi_mosi, spi_sclk_rise, spi_sclk_fall, i2c_scl, i2c_sda_in;
    logic scl_rate_fault, core_reset, clock_enable, cts_n_sync, rx_sync;
    logic [NUM_GPIO-1:0] general_pin_o, general_pin_oe, gpio_in_data;
    logic [STRAP_W-1:0] addr_strap;
    logic [7:0] mosi_sh = 8'h00;
    int n_rise = 0, n_fall = 0, n_mismatch = 0, compares = 0;

    always #12.5 sys_clk = !sys_clk;
    assign dout_sda_i = ((dout_sda_oe === 1'h1 && dout_sda_o !== 1'h1) || sda_low) ? 1'h0 : 1'h1;
    assign general_pin_i = (general_pin_oe & general_pin_o) | (~general_pin_oe & gpio_ext);

    hps_pin_select dut (.sys_clk, .rst, .reset_n_pin, .spi_select_pin, .sclk_scl_pin,
        .select_or_addr_strap0, .serial_in_or_addr_strap1, .dout_sda_i, .dout_sda_o,
        .dout_sda_oe, .irq_n_o, .irq_n_oe, .clear_to_send_n, .rx_pin, .tx_pin,
        .request_to_send_n, .general_pin_i, .general_pin_o, .general_pin_oe, .spi_miso,
        .i2c_sda_drive_low, .irq_pending, .line_control_register, .tx_data, .gpio_dir_out,
        .gpio_open_drain, .gpio_out_data, .mode_spi, .addr_strap, .spi_cs_n, .spi_mosi,
        .spi_sclk_rise, .spi_sclk_fall, .i2c_scl, .i2c_sda_in, .scl_rate_fault, .core_reset,
        .clock_enable, .cts_n_sync, .rx_sync, .gpio_in_data);
    hps_host_model host (.sel(spi_select_pin), .sclk(sclk_scl_pin),
        .cs_strap0(select_or_addr_strap0), .din_strap1(serial_in_or_addr_strap1),
        .sda_low(sda_low), .sda_wire(dout_sda_i));

    always @(posedge sys_clk) begin
        if (spi_sclk_rise === 1'h1) begin
            n_rise <= n_rise + 1;
            mosi_sh <= {mosi_sh[6:0], spi_mosi};
        end
        if (spi_sclk_fall === 1'h1) begin
            n_fall <= n_fall + 1;
        end
    end
    // ==========================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic hold_reset(input logic mode, input logic [1:0] a);
        reset_n_pin = 1'h0;
        host.strap(mode, a);
        cyc(4);
        chk({core_reset, clock_enable}, 2'h2, "core held");
        chk({irq_n_oe, tx_pin}, 2'h1, "irq and tx idle");
    endtask
    task automatic leave_reset;
        int i;
        reset_n_pin = 1'h1;
        for (i = 0; i < 20 && clock_enable !== 1'h1; i++) cyc(1);
        if (i == 20) begin
            n_mismatch++;
            $display("mismatch at %0t: reset release timed out", $time);
            results();
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        #2;
        rst = 1'h0;
        hold_reset(1'h1, 2'h0);
        host.spi_byte(8'hFF);
        chk(8'(n_rise + n_fall), 8'h00, "no edges in reset");
        leave_reset();
        chk({mode_spi, spi_cs_n}, 2'h3, "spi mode idle");
        host.spi_byte(8'hA5);
        cyc(4);
        chk(8'(n_rise), 8'h08, "sclk rises");
        chk(8'(n_fall), 8'h08, "sclk falls");
        chk(mosi_sh, 8'hA5, "mosi");
        chk(host.rx, 8'h00, "dout read back");
        chk(dout_sda_oe, 1'h0, "dout released");
        spi_miso = 1'h1;
        host.spi_byte(8'h3C);
        cyc(4);
        chk(mosi_sh, 8'h3C, "mosi second byte");
        chk(host.rx, 8'hFF, "miso routed");
        spi_miso = 1'h0;
        irq_pending = 1'h1;
        cyc(1);
        chk({irq_n_oe, irq_n_o}, 2'h2, "irq pulled");
        irq_pending = 1'h0;
        cyc(1);
        chk(irq_n_oe, 1'h0, "irq released");
        for (int v = 0; v < 2; v++) begin
            line_control_register = {v[0], 7'h05};
            cyc(1);
            chk(request_to_send_n, v[0], "rts");
        end
        tx_data = 1'h0;
        rx_pin = 1'h0;
        clear_to_send_n = 1'h0;
        cyc(3);
        chk({tx_pin, rx_sync, cts_n_sync}, 3'h0, "serial pins");
        rx_pin = 1'h1;
        clear_to_send_n = 1'h1;
        for (int c = 0; c < 8; c++) begin
            gpio_dir_out = {4{c[2]}};
            gpio_open_drain = {4{c[1]}};
            gpio_out_data = {2'h1, c[0], !c[0]};
            cyc(5);
            chk(general_pin_o, c[1] ? 4'h0 : gpio_out_data, "gpio out");
            chk(general_pin_oe, gpio_dir_out & (~gpio_open_drain | ~gpio_out_data), "oe");
            // a released pin shows the outside level, a driven pin the drive
            pin_exp = (gpio_dir_out & ~gpio_open_drain & gpio_out_data) |
                ((~gpio_dir_out | (gpio_open_drain & gpio_out_data)) & gpio_ext);
            chk(gpio_in_data, pin_exp, "gpio in");
        end
        irq_pending = 1'h1;
        hold_reset(1'h0, 2'h2);
        irq_pending = 1'h0;
        tx_data = 1'h1;
        leave_reset();
        chk({mode_spi, addr_strap, spi_cs_n}, 4'h5, "i2c mode straps");
        host.scl_pulses(3, 1300);
        chk({i2c_scl, scl_rate_fault}, 2'h2, "slow scl");
        i2c_sda_drive_low = 1'h1;
        cyc(1);
        chk({dout_sda_oe, dout_sda_o}, 2'h2, "sda drive");
        cyc(3);
        chk(i2c_sda_in, 1'h0, "sda loop");
        i2c_sda_drive_low = 1'h0;
        host.scl_pulses(2, 100);
        cyc(3);
        chk(scl_rate_fault, 1'h1, "fast scl");
        results();
    end
endmodule
